//--- src/flash_cfg_pkg.sv
/*
  Shared constants for the serial flash configuration register block: command
  codes, field positions, reset values and the link-side state encoding.
  Assumes nothing of its surroundings; both design modules refer to it by name.
*/
package flash_cfg_pkg;

  // Register commands.
  localparam logic [7:0] OP_WRITE_REGS = 8'h01;
  localparam logic [7:0] OP_READ_CFG   = 8'h35;

  // Read commands, plain and four-byte-address forms.
  localparam logic [7:0] OP_READ       = 8'h03;
  localparam logic [7:0] OP_READ_4B    = 8'h13;
  localparam logic [7:0] OP_FAST       = 8'h0B;
  localparam logic [7:0] OP_FAST_4B    = 8'h0C;
  localparam logic [7:0] OP_DOUT       = 8'h3B;
  localparam logic [7:0] OP_DOUT_4B    = 8'h3C;
  localparam logic [7:0] OP_QOUT       = 8'h6B;
  localparam logic [7:0] OP_QOUT_4B    = 8'h6C;
  localparam logic [7:0] OP_DIO        = 8'hBB;
  localparam logic [7:0] OP_DIO_4B     = 8'hBC;
  localparam logic [7:0] OP_QIO        = 8'hEB;
  localparam logic [7:0] OP_QIO_4B     = 8'hEC;
  localparam logic [7:0] OP_DDR_FAST   = 8'h0D;
  localparam logic [7:0] OP_DDR_FAST4B = 8'h0E;
  localparam logic [7:0] OP_DDR_DIO    = 8'hBD;
  localparam logic [7:0] OP_DDR_DIO_4B = 8'hBE;
  localparam logic [7:0] OP_DDR_QIO    = 8'hED;
  localparam logic [7:0] OP_DDR_QIO_4B = 8'hEE;

  // Field positions in config_reg_one.
  localparam int unsigned CFG_LAT_HI     = 7;
  localparam int unsigned CFG_LAT_LO     = 6;
  localparam int unsigned CFG_PROT_LOW   = 5;
  localparam int unsigned CFG_RESERVED   = 4;
  localparam int unsigned CFG_BP_VOL     = 3;
  localparam int unsigned CFG_PARAM_HI   = 2;
  localparam int unsigned CFG_QUAD       = 1;
  localparam int unsigned CFG_FREEZE     = 0;
  localparam logic [7:0]  CFG_RESET      = 8'h00;
  localparam logic [7:0]  CFG_OTP_MASK   = 8'h2C;
  localparam logic [7:0]  CFG_FROZEN     = 8'h24;

  // Block-protect field inside status register 1.
  localparam int unsigned SR_BP_HI       = 4;
  localparam int unsigned SR_BP_LO       = 2;
  localparam logic [2:0]  BP_RESET       = 3'h0;
  localparam logic [2:0]  BP_VOL_RESET   = 3'h7;

  // Upper mode nibble that asks for a repeat of the same read type.
  localparam logic [3:0]  CONT_NIBBLE    = 4'hA;
  localparam logic [3:0]  DLP_MIN_DUMMY  = 4'h5;
  localparam logic [4:0]  BITS_ONE_BYTE  = 5'h08;
  localparam logic [4:0]  BITS_TWO_BYTES = 5'h10;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_OPCODE = 3'b001,
    ST_WRITE  = 3'b010,
    ST_RDCFG  = 3'b011,
    ST_READ   = 3'b100,
    ST_IGNORE = 3'b101
  } link_state_t;

  function automatic logic is_read_op(input logic [7:0] op);
    case (op)
      OP_READ, OP_READ_4B, OP_FAST, OP_FAST_4B, OP_DOUT, OP_DOUT_4B,
      OP_QOUT, OP_QOUT_4B, OP_DIO, OP_DIO_4B, OP_QIO, OP_QIO_4B,
      OP_DDR_FAST, OP_DDR_FAST4B, OP_DDR_DIO, OP_DDR_DIO_4B,
      OP_DDR_QIO, OP_DDR_QIO_4B: is_read_op = 1'b1;
      default:                   is_read_op = 1'b0;
    endcase
  endfunction

endpackage

//--- src/latency_table.sv
/*
  Read latency lookup: mode and dummy cycle counts for the current read command
  and latency code, plus whether a learning pattern fits in the dummy cycles of a DDR read.
  Assumes command and code are stable ref_clk_i signals; results are registered.
*/
`timescale 1ns/10ps
`default_nettype none

module latency_table #(
  parameter int unsigned LATENCY_SET = 0
) (
  // Clock and reset.
  input  wire logic       ref_clk_i,
  input  wire logic       nrst_i,
  // Lookup key.
  input  wire logic [7:0] cmd_i,
  input  wire logic [1:0] lat_code_i,
  // Registered result.
  output logic      [2:0] mode_cycles_o,
  output logic      [3:0] dummy_cycles_o,
  output logic            dlp_ok_o
);

  // Tables read left to right for codes 11, 00, 01, 10.
  function automatic logic [3:0] pick(input logic [15:0] tbl, input logic [1:0] idx);
    pick = tbl[{~idx, 2'b11} -: 4];
  endfunction

  logic       enh;
  logic [1:0] idx;
  logic [2:0] mode_nxt;
  logic [3:0] dummy_nxt;
  logic       ddr;

  assign enh = (LATENCY_SET == 1);
  assign idx = lat_code_i + 2'h1;

  always_comb begin
    mode_nxt  = 3'h0;
    dummy_nxt = 4'h0;
    ddr       = 1'b0;
    case (cmd_i)
      flash_cfg_pkg::OP_READ, flash_cfg_pkg::OP_READ_4B: begin
        dummy_nxt = 4'h0;
      end
      flash_cfg_pkg::OP_FAST, flash_cfg_pkg::OP_FAST_4B, flash_cfg_pkg::OP_DOUT,
      flash_cfg_pkg::OP_DOUT_4B, flash_cfg_pkg::OP_QOUT, flash_cfg_pkg::OP_QOUT_4B: begin
        dummy_nxt = pick(16'h0888, idx);
      end
      flash_cfg_pkg::OP_DIO, flash_cfg_pkg::OP_DIO_4B: begin
        mode_nxt  = enh ? 3'h4 : 3'h0;
        dummy_nxt = pick(enh ? 16'h0012 : 16'h4456, idx);
      end
      flash_cfg_pkg::OP_QIO, flash_cfg_pkg::OP_QIO_4B: begin
        mode_nxt  = 3'h2;
        dummy_nxt = pick(16'h1445, idx);
      end
      flash_cfg_pkg::OP_DDR_FAST, flash_cfg_pkg::OP_DDR_FAST4B: begin
        ddr       = 1'b1;
        mode_nxt  = enh ? 3'h4 : 3'h0;
        dummy_nxt = pick(enh ? 16'h1245 : 16'h4567, idx);
      end
      flash_cfg_pkg::OP_DDR_DIO, flash_cfg_pkg::OP_DDR_DIO_4B: begin
        ddr       = 1'b1;
        mode_nxt  = enh ? 3'h2 : 3'h0;
        dummy_nxt = pick(enh ? 16'h2456 : 16'h4678, idx);
      end
      flash_cfg_pkg::OP_DDR_QIO, flash_cfg_pkg::OP_DDR_QIO_4B: begin
        ddr       = 1'b1;
        mode_nxt  = 3'h1;
        dummy_nxt = pick(16'h3678, idx);
      end
      default: begin
        mode_nxt  = 3'h0;
        dummy_nxt = 4'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_cycles_o  <= 3'h0;
      dummy_cycles_o <= 4'h0;
      dlp_ok_o       <= 1'b0;
    end else begin
      mode_cycles_o  <= mode_nxt;
      dummy_cycles_o <= dummy_nxt;
      dlp_ok_o       <= ddr && (dummy_nxt >= flash_cfg_pkg::DLP_MIN_DUMMY);
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  AST_LUT_PLAIN_READ: assert property ((cmd_i == flash_cfg_pkg::OP_READ) |=>
    (mode_cycles_o == 3'h0) && (dummy_cycles_o == 4'h0))
    else $error("plain read got latency cycles");
  AST_LUT_FAST: assert property ((cmd_i == flash_cfg_pkg::OP_FAST) |=>
    (dummy_cycles_o == (($past(lat_code_i) == 2'h3) ? 4'h0 : 4'h8)))
    else $error("fast read dummy count wrong");
  AST_LUT_DLP: assert property (dlp_ok_o |-> dummy_cycles_o >= 4'h5)
    else $error("learning pattern allowed with too few dummy cycles");

endmodule

`default_nettype wire

//--- src/flash_cfg_reg.sv
/*
  Configuration register of a serial NOR flash with its command front end.
  Samples the serial link (clock, select, data in) with ref_clk_i, decodes the
  register write, register read and read commands, keeps the configuration
  and block-protect bits, and reports the read latency for the read engine.
  Assumes the stored nonvolatile image is presented on nv_cfg_i and nv_bp_i
  at reset release, and that wel_i, soft_reset_i, clr_status_i and the mode
  byte come from logic on ref_clk_i.
*/
`timescale 1ns/10ps
`default_nettype none

module flash_cfg_reg #(
  parameter int unsigned LATENCY_SET = 0
) (
  // Clock and reset.
  input  wire logic       ref_clk_i,
  input  wire logic       nrst_i,
  // Serial link pins.
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic       si_i,
  input  wire logic       wp_n_i,
  input  wire logic       hold_n_i,
  output logic            so_o,
  output logic            so_oe_o,
  // Stored nonvolatile image and device control.
  input  wire logic [7:0] nv_cfg_i,
  input  wire logic [2:0] nv_bp_i,
  input  wire logic       wel_i,
  input  wire logic       soft_reset_i,
  input  wire logic       clr_status_i,
  // Mode byte from the read engine.
  input  wire logic [7:0] mode_byte_i,
  input  wire logic       mode_valid_i,
  // Configuration and status.
  output logic      [7:0] cfg_o,
  output logic      [2:0] bp_o,
  output logic            prog_err_o,
  output logic            wp_n_eff_o,
  output logic            hold_n_eff_o,
  // Read engine steering.
  output logic            read_active_o,
  output logic      [7:0] read_cmd_o,
  output logic            cont_read_o,
  output logic      [2:0] mode_cycles_o,
  output logic      [3:0] dummy_cycles_o,
  output logic            dlp_ok_o
);

  generate
    if (LATENCY_SET > 1) begin : g_bad_set
      $error("LATENCY_SET must be 0 or 1");
    end
  endgenerate

  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic       sck_d_r;
  logic       cs_n_d_r;
  logic       sck_rise;
  logic       sck_fall;
  logic       frame_start;
  logic       frame_end;

  flash_cfg_pkg::link_state_t state_r;
  logic [4:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] cmd_r;
  logic [7:0] wr_sr_r;
  logic [7:0] wr_cfg_r;
  logic [2:0] out_idx_r;
  logic       cont_r;
  logic       load_pend_r;
  logic [7:0] cfg_r;
  logic [2:0] bp_r;
  logic       prog_err_r;
  logic [7:0] cfg_nxt;
  logic       otp_err;
  logic       commit;
  logic [7:0] shift_nxt;

  // Pins pass two flops; the second stage and a one-cycle-delayed copy of its clock and select bits are looked at.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_r  <= 5'h1F;
      sync2_r  <= 5'h1F;
      sck_d_r  <= 1'b1;
      cs_n_d_r <= 1'b1;
    end else begin
      sync1_r  <= {hold_n_i, wp_n_i, si_i, cs_n_i, sck_i};
      sync2_r  <= sync1_r;
      sck_d_r  <= sync2_r[0];
      cs_n_d_r <= sync2_r[1];
    end
  end

  assign sck_rise    = sync2_r[0] & ~sck_d_r & ~sync2_r[1];
  assign sck_fall    = ~sync2_r[0] & sck_d_r & ~sync2_r[1];
  assign frame_start = ~sync2_r[1] & cs_n_d_r;
  assign frame_end   = sync2_r[1] & ~cs_n_d_r;
  assign shift_nxt   = {shift_r[6:0], sync2_r[2]};

  // Command framing: bits are taken on rising edges, MSB first.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r   <= flash_cfg_pkg::ST_IDLE;
      bit_cnt_r <= 5'h00;
      shift_r   <= 8'h00;
      cmd_r     <= 8'h00;
      wr_sr_r   <= 8'h00;
      wr_cfg_r  <= 8'h00;
    end else if (soft_reset_i || frame_end) begin
      state_r   <= flash_cfg_pkg::ST_IDLE;
      bit_cnt_r <= (soft_reset_i) ? 5'h00 : bit_cnt_r;
    end else if (frame_start) begin
      bit_cnt_r <= 5'h00;
      // A continuation frame starts straight at the address.
      state_r   <= cont_r ? flash_cfg_pkg::ST_READ : flash_cfg_pkg::ST_OPCODE;
    end else if (sck_rise) begin
      shift_r <= shift_nxt;
      case (state_r)
        flash_cfg_pkg::ST_OPCODE: begin
          bit_cnt_r <= bit_cnt_r + 5'h01;
          if (bit_cnt_r == 5'h07) begin
            bit_cnt_r <= 5'h00;
            if (shift_nxt == flash_cfg_pkg::OP_WRITE_REGS) begin
              state_r <= flash_cfg_pkg::ST_WRITE;
            end else if (shift_nxt == flash_cfg_pkg::OP_READ_CFG) begin
              state_r <= flash_cfg_pkg::ST_RDCFG;
            end else if (flash_cfg_pkg::is_read_op(shift_nxt)) begin
              state_r <= flash_cfg_pkg::ST_READ;
              cmd_r   <= shift_nxt;
            end else begin
              state_r <= flash_cfg_pkg::ST_IGNORE;
            end
          end
        end
        flash_cfg_pkg::ST_WRITE: begin
          if (bit_cnt_r < flash_cfg_pkg::BITS_TWO_BYTES) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
          end
          if (bit_cnt_r == 5'h07) begin
            wr_sr_r <= shift_nxt;
          end
          if (bit_cnt_r == 5'h0F) begin
            wr_cfg_r <= shift_nxt;
          end
        end
        default: begin
          bit_cnt_r <= bit_cnt_r;
        end
      endcase
    end
  end

  // Register write takes effect when the frame closes after exactly one data byte or after two or more.
  assign commit = frame_end && (state_r == flash_cfg_pkg::ST_WRITE) && wel_i &&
                  ((bit_cnt_r == flash_cfg_pkg::BITS_ONE_BYTE) ||
                   (bit_cnt_r == flash_cfg_pkg::BITS_TWO_BYTES));

  always_comb begin
    cfg_nxt = cfg_r;
    otp_err = 1'b0;
    if (bit_cnt_r == flash_cfg_pkg::BITS_TWO_BYTES) begin
      cfg_nxt[flash_cfg_pkg::CFG_LAT_HI] = wr_cfg_r[flash_cfg_pkg::CFG_LAT_HI];
      cfg_nxt[flash_cfg_pkg::CFG_LAT_LO] = wr_cfg_r[flash_cfg_pkg::CFG_LAT_LO];
      cfg_nxt[flash_cfg_pkg::CFG_QUAD]   = wr_cfg_r[flash_cfg_pkg::CFG_QUAD];
      // Programmed OTP bits only ever stay at one.
      cfg_nxt = cfg_nxt | (wr_cfg_r & flash_cfg_pkg::CFG_OTP_MASK);
      otp_err = |(cfg_r & ~wr_cfg_r & flash_cfg_pkg::CFG_OTP_MASK);
      if (cfg_r[flash_cfg_pkg::CFG_FREEZE]) begin
        // Frozen placement bits neither change nor raise an error.
        cfg_nxt = (cfg_nxt & ~flash_cfg_pkg::CFG_FROZEN) |
                  (cfg_r & flash_cfg_pkg::CFG_FROZEN);
        otp_err = |(cfg_r & ~wr_cfg_r & flash_cfg_pkg::CFG_OTP_MASK &
                    ~flash_cfg_pkg::CFG_FROZEN);
      end
      cfg_nxt[flash_cfg_pkg::CFG_FREEZE]   = cfg_r[flash_cfg_pkg::CFG_FREEZE] |
                                             wr_cfg_r[flash_cfg_pkg::CFG_FREEZE];
      cfg_nxt[flash_cfg_pkg::CFG_RESERVED] = 1'b0;
    end
  end

  // Configuration and block-protect bits.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_r       <= flash_cfg_pkg::CFG_RESET;
      bp_r        <= flash_cfg_pkg::BP_RESET;
      load_pend_r <= 1'b1;
    end else if (load_pend_r) begin
      // The stored image is taken at the first edge after release; freeze starts clear.
      load_pend_r <= 1'b0;
      cfg_r       <= nv_cfg_i & ~flash_cfg_pkg::CFG_OTP_MASK & 8'hC2 |
                     nv_cfg_i & flash_cfg_pkg::CFG_OTP_MASK;
      bp_r        <= nv_cfg_i[flash_cfg_pkg::CFG_BP_VOL] ? flash_cfg_pkg::BP_VOL_RESET :
                     nv_bp_i;
    end else if (soft_reset_i) begin
      // Software reset keeps freeze and every other configuration bit.
      if (cfg_r[flash_cfg_pkg::CFG_BP_VOL]) begin
        bp_r <= flash_cfg_pkg::BP_VOL_RESET;
      end
    end else if (commit) begin
      cfg_r <= cfg_nxt;
      if (!cfg_r[flash_cfg_pkg::CFG_FREEZE]) begin
        bp_r <= wr_sr_r[flash_cfg_pkg::SR_BP_HI:flash_cfg_pkg::SR_BP_LO];
      end
    end
  end

  // Program error is sticky; a new error beats a clear in the same cycle.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prog_err_r <= 1'b0;
    end else if (commit && otp_err) begin
      prog_err_r <= 1'b1;
    end else if (clr_status_i) begin
      prog_err_r <= 1'b0;
    end
  end

  // Configuration readback shifts out on falling edges and wraps every byte.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      so_o      <= 1'b0;
      so_oe_o   <= 1'b0;
      out_idx_r <= 3'h7;
    end else if (state_r != flash_cfg_pkg::ST_RDCFG) begin
      so_oe_o   <= 1'b0;
      out_idx_r <= 3'h7;
    end else if (sck_fall) begin
      so_oe_o   <= 1'b1;
      so_o      <= cfg_r[out_idx_r];
      out_idx_r <= out_idx_r - 3'h1;
    end
  end

  // Continuation request is judged from the mode byte of the running read.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cont_r <= 1'b0;
    end else if (soft_reset_i) begin
      cont_r <= 1'b0;
    end else if (mode_valid_i && (state_r == flash_cfg_pkg::ST_READ)) begin
      cont_r <= (mode_byte_i[7:4] == flash_cfg_pkg::CONT_NIBBLE);
    end else if (frame_start) begin
      // A continuation covers one frame only; that frame's mode byte must re-arm it.
      cont_r <= 1'b0;
    end
  end

  // Pin functions and read-engine status, all registered.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_n_eff_o    <= 1'b1;
      hold_n_eff_o  <= 1'b1;
      read_active_o <= 1'b0;
      read_cmd_o    <= 8'h00;
      cont_read_o   <= 1'b0;
    end else begin
      wp_n_eff_o    <= cfg_r[flash_cfg_pkg::CFG_QUAD] | sync2_r[3];
      hold_n_eff_o  <= cfg_r[flash_cfg_pkg::CFG_QUAD] | sync2_r[4];
      read_active_o <= (state_r == flash_cfg_pkg::ST_READ);
      read_cmd_o    <= cmd_r;
      cont_read_o   <= cont_r;
    end
  end

  assign cfg_o      = cfg_r;
  assign bp_o       = bp_r;
  assign prog_err_o = prog_err_r;

  latency_table #(
    .LATENCY_SET (LATENCY_SET)
  ) u_latency (
    .ref_clk_i      (ref_clk_i),
    .nrst_i         (nrst_i),
    .cmd_i          (cmd_r),
    .lat_code_i     (cfg_r[flash_cfg_pkg::CFG_LAT_HI:flash_cfg_pkg::CFG_LAT_LO]),
    .mode_cycles_o  (mode_cycles_o),
    .dummy_cycles_o (dummy_cycles_o),
    .dlp_ok_o       (dlp_ok_o)
  );

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  AST_WRITE_LATENCY: assert property (commit && (bit_cnt_r == 5'h10) |=>
    cfg_r[7:6] == $past(wr_cfg_r[7:6]))
    else $error("latency code not loaded by register write");
  AST_READBACK_BIT: assert property ((state_r == flash_cfg_pkg::ST_RDCFG) && sck_fall |=>
    so_oe_o && (so_o == cfg_r[$past(out_idx_r)]))
    else $error("configuration readback bit wrong");
  AST_RESERVED_ZERO: assert property (cfg_o[4] == 1'b0)
    else $error("reserved bit reads one");
  AST_OTP_STAYS: assert property (!load_pend_r && $past(!load_pend_r) |->
    ((cfg_r & 8'h2C) & $past(cfg_r & 8'h2C)) == $past(cfg_r & 8'h2C))
    else $error("programmed OTP bit returned to zero");
  AST_OTP_ERROR: assert property (commit && otp_err |=> prog_err_o)
    else $error("failed OTP clear did not flag error");
  AST_FREEZE_KEEPS: assert property (cfg_r[0] && !load_pend_r |=>
    cfg_r[0] && $stable(cfg_r[5]) && $stable(cfg_r[2]))
    else $error("freeze or frozen bit changed");
  AST_FROZEN_BP: assert property (cfg_r[0] && !soft_reset_i && !load_pend_r |=>
    $stable(bp_r))
    else $error("block-protect bits changed while frozen");
  AST_VOL_BP_RESET: assert property (soft_reset_i && cfg_r[3] && !load_pend_r |=>
    bp_r == 3'h7)
    else $error("volatile protect bits not set to all ones");
  AST_QUAD_PINS: assert property (cfg_r[1] |=> wp_n_eff_o && hold_n_eff_o)
    else $error("protect or hold pin active in quad width");
  AST_CONT_FRAME: assert property (frame_start && cont_r && !soft_reset_i &&
    !frame_end |=> state_r == flash_cfg_pkg::ST_READ ##1 read_active_o)
    else $error("continuation frame did not enter read");

  COV_WRITE16: cover property (commit && (bit_cnt_r == 5'h10));
  COV_READBACK: cover property ((state_r == flash_cfg_pkg::ST_RDCFG) && sck_fall);
  COV_OTP_ERR: cover property (commit && otp_err);
  COV_CONT: cover property (frame_start && cont_r);

endmodule

`default_nettype wire

//--- test/spi_host_model.sv
/*
  Host model of the serial link: drives clock, select and data toward the block.
  Assumes the bench clock on clk_i; the link clock runs at 80 ns only in frames.
*/
`timescale 1ns/10ps
`default_nettype none

module spi_host_model (
  // Bench clock.
  input  wire logic clk_i,
  // Link pins.
  input  wire logic so_i,
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o
);
  initial begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end

  // Sends n bits MSB first from bits[23] and collects the answer bits.
  task automatic xfer(input logic [23:0] bits, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      si_o = bits[i];
      repeat (8) @(negedge clk_i);
      sck_o = 1'b1;
      rd    = {rd[6:0], so_i};
      repeat (8) @(negedge clk_i);
      sck_o = 1'b0;
    end
    repeat (8) @(negedge clk_i);
  endtask

  // Select rises between commands; the released data line shows no stale value.
  task automatic stop();
    cs_n_o = 1'b1;
    si_o   = ~si_o;
    repeat (10) @(negedge clk_i);
  endtask
endmodule

`default_nettype wire

//--- test/tb.sv
/*
  Self-checking bench for the configuration register block.
  Assumes the host model drives the link and the bench drives the side inputs.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic       clk = 1'b0;
  logic       rst_n, wp_n, hold_n, wel, srst, clr, mvalid;
  logic       sck, cs_n, si, so, so_oe, perr, wp_eff, hold_eff, ract, cont, learning_pattern;
  logic [7:0] nv_cfg, mbyte, cfg, rcmd, rd;
  logic [2:0] nv_bp, bp, mc;
  logic [3:0] dc;
  logic       so_pin, dlp_e;
  logic [2:0] mc_e;
  logic [3:0] dc_e;
  int         n_errors = 0;
  int         total_checks = 0;
  int         cyc = 0;
  logic [7:0]  ops [7] = '{8'h03, 8'h0B, 8'hBB, 8'hEB, 8'h0D, 8'hBD, 8'hED};
  logic [2:0]  mds [7] = '{3'h0, 3'h0, 3'h0, 3'h2, 3'h0, 3'h0, 3'h1};
  // Dummy counts per code, nibble index equals the latency code.
  logic [15:0] dms [7] = '{16'h0000, 16'h0888, 16'h4654, 16'h1544, 16'h4765, 16'h4876,
                           16'h3876};
  // Enhanced latency set, same layout.
  logic [2:0]  mde [7] = '{3'h0, 3'h0, 3'h4, 3'h2, 3'h4, 3'h2, 3'h1};
  logic [15:0] dme [7] = '{16'h0000, 16'h0888, 16'h0210, 16'h1544, 16'h1542, 16'h2654,
                           16'h3876};

  always #2.5 clk = ~clk;

  flash_cfg_reg #(.LATENCY_SET(0)) u_dut (
    .ref_clk_i(clk), .nrst_i(rst_n), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .wp_n_i(wp_n), .hold_n_i(hold_n), .so_o(so), .so_oe_o(so_oe), .nv_cfg_i(nv_cfg),
    .nv_bp_i(nv_bp), .wel_i(wel), .soft_reset_i(srst), .clr_status_i(clr),
    .mode_byte_i(mbyte), .mode_valid_i(mvalid), .cfg_o(cfg), .bp_o(bp),
    .prog_err_o(perr), .wp_n_eff_o(wp_eff), .hold_n_eff_o(hold_eff),
    .read_active_o(ract), .read_cmd_o(rcmd), .cont_read_o(cont),
    .mode_cycles_o(mc), .dummy_cycles_o(dc), .dlp_ok_o(learning_pattern));

  flash_cfg_reg #(.LATENCY_SET(1)) u_dut_enh (
    .ref_clk_i(clk), .nrst_i(rst_n), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .wp_n_i(wp_n), .hold_n_i(hold_n), .so_o(), .so_oe_o(), .nv_cfg_i(nv_cfg),
    .nv_bp_i(nv_bp), .wel_i(wel), .soft_reset_i(srst), .clr_status_i(clr),
    .mode_byte_i(mbyte), .mode_valid_i(mvalid), .cfg_o(), .bp_o(),
    .prog_err_o(), .wp_n_eff_o(), .hold_n_eff_o(),
    .read_active_o(), .read_cmd_o(), .cont_read_o(),
    .mode_cycles_o(mc_e), .dummy_cycles_o(dc_e), .dlp_ok_o(dlp_e));

  // A released output line shows the inverse of its last bit, so stale data cannot pass.
  assign so_pin = so_oe ? so : ~so;

  spi_host_model u_host (.clk_i(clk), .so_i(so_pin), .sck_o(sck), .cs_n_o(cs_n), .si_o(si));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    total_checks++;
    if (got !== ex) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic wr(input logic [7:0] sr, input logic [7:0] cr);
    u_host.xfer({8'h01, sr, cr}, 24, rd);
    u_host.stop();
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic hw_reset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      $display("[ERR] cycle limit expected 0 seen %0d", cyc);
      complete_run();
    end
  end

  initial begin
    {wel, srst, clr, mvalid, wp_n, hold_n} = 6'h20;
    rst_n  = 1'b0;
    nv_cfg = 8'h00;
    nv_bp  = 3'h5;
    mbyte  = 8'h00;
    hw_reset();
    chk("cfg", 8'h00, cfg);
    chk("bp", 8'h05, {5'h00, bp});
    chk("pins", 8'h00, {6'h00, wp_eff, hold_eff});
    $display("test reset done");
    wr(8'h1C, 8'hD2);
    chk("cfg", 8'hC2, cfg);
    chk("bp", 8'h07, {5'h00, bp});
    chk("pins", 8'h03, {6'h00, wp_eff, hold_eff});
    u_host.xfer({8'h35, 16'h0000}, 16, rd);
    chk("readback", 8'hC2, rd);
    u_host.stop();
    chk("so_oe", 8'h00, {7'h00, so_oe});
    wel = 1'b0;
    wr(8'h00, 8'h00);
    chk("cfg", 8'hC2, cfg);
    chk("bp", 8'h07, {5'h00, bp});
    wel = 1'b1;
    $display("test write done");
    // The slow bench link clock suits every code, so any code may stay set.
    for (int code = 0; code < 4; code++) begin
      wr(8'h00, {code[1:0], 6'h00});
      for (int c = 0; c < 7; c++) begin
        u_host.xfer({ops[c], 16'h0000}, 8, rd);
        chk("mode", {5'h00, mds[c]}, {5'h00, mc});
        chk("dummy", {4'h0, dms[c][code*4 +: 4]}, {4'h0, dc});
        chk("mode_e", {5'h00, mde[c]}, {5'h00, mc_e});
        chk("dummy_e", {4'h0, dme[c][code*4 +: 4]}, {4'h0, dc_e});
        if (c > 3) begin
          chk("dlp", {7'h00, dms[c][code*4 +: 4] >= 4'h5}, {7'h00, learning_pattern});
          chk("dlp_e", {7'h00, dme[c][code*4 +: 4] >= 4'h5}, {7'h00, dlp_e});
        end
        u_host.stop();
      end
    end
    $display("test latency done");
    u_host.xfer({8'hEB, 16'h0000}, 8, rd);
    mbyte  = 8'hA5;
    mvalid = 1'b1;
    @(negedge clk);
    mvalid = 1'b0;
    repeat (4) @(negedge clk);
    chk("cont", 8'h01, {7'h00, cont});
    u_host.stop();
    u_host.xfer(24'h123456, 24, rd);
    chk("active", 8'h01, {7'h00, ract});
    chk("rcmd", 8'hEB, rcmd);
    chk("cont", 8'h00, {7'h00, cont});
    u_host.stop();
    $display("test continuation done");
    wr(8'h1C, 8'h25);
    chk("cfg", 8'h25, cfg);
    wr(8'h00, 8'h00);
    chk("cfg", 8'h25, cfg);
    chk("bp", 8'h07, {5'h00, bp});
    pulse(srst);
    chk("cfg", 8'h25, cfg);
    nv_cfg = 8'h08;
    hw_reset();
    chk("cfg", 8'h08, cfg);
    chk("bp", 8'h07, {5'h00, bp});
    wr(8'h00, 8'h00);
    chk("cfg", 8'h08, cfg);
    chk("bp", 8'h00, {5'h00, bp});
    chk("perr", 8'h01, {7'h00, perr});
    pulse(clr);
    chk("perr", 8'h00, {7'h00, perr});
    pulse(srst);
    chk("bp", 8'h07, {5'h00, bp});
    $display("test protection done");
    complete_run();
  end
endmodule

`default_nettype wire
